// File: design/bbc_map.vh
`ifndef BBC_MAP_VH
`define BBC_MAP_VH

// Opcode classes, taken from opcode[2:0]
`define BBC_CLS_IFNZ     3'h0
`define BBC_CLS_JUMP     3'h1
`define BBC_CLS_IFNC     3'h2
`define BBC_CLS_BIT      3'h3
`define BBC_CLS_IFZ      3'h4
`define BBC_CLS_IFC      3'h6
// Field positions
`define BBC_SUB_BIT      3
`define BBC_POL_BIT      4
// Control opcodes
`define BBC_OP_IDLE      8'h05
`define BBC_OP_RET       8'h25
`define BBC_OP_INTRET    8'h45
`define BBC_OP_STOP      8'h65
`define BBC_OP_WAIT      8'h85
// Instruction lengths in bytes
`define BBC_LEN_SHORT    12'h001
`define BBC_LEN_BITOP    12'h002
`define BBC_LEN_BITTEST  12'h003
`define BBC_LEN_JUMP     12'h002
// Branch offset bias so that the reach is -15..+16 and -126..+129
`define BBC_BIAS_SHORT   12'h001
`define BBC_BIAS_LONG    12'h002
// Instruction cycle counts
`define BBC_CYC_SHORT    3'h2
`define BBC_CYC_BITOP    3'h4
`define BBC_CYC_BITTEST  3'h5
`define BBC_CYC_JUMP     3'h4
`define BBC_CYC_CTRL     3'h2
// Return stack
`define BBC_STACK_DEPTH  6
`define BBC_STACK_PTR_W  3
`define BBC_PC_RESET     12'h000

`endif

// File: design/bbc_return_stack.v
`timescale 1ns/1ps
`include "bbc_map.vh"

module bbc_return_stack (
   // Clock and reset
   input  wire        i_clock,
   input  wire        i_rst,
   // Stack operations
   input  wire        i_push,
   input  wire        i_pop,
   input  wire [11:0] i_push_addr,
   // Stack state
   output reg  [11:0] o_top,
   output wire        o_empty
);

   reg [11:0]                   slot [0:`BBC_STACK_DEPTH-1];
   reg [`BBC_STACK_PTR_W-1:0]   depth;
   integer                      k;

   assign o_empty = (depth == {`BBC_STACK_PTR_W{1'b0}});

   // Full stack drops the oldest return address, as a fixed-depth shift stack does
   always @(posedge i_clock) begin
      if (i_rst) begin
         depth <= {`BBC_STACK_PTR_W{1'b0}};
         o_top <= `BBC_PC_RESET;
         for (k = 0; k < `BBC_STACK_DEPTH; k = k + 1) begin
            slot[k] <= `BBC_PC_RESET;
         end
      end else if (i_push) begin
         slot[0] <= i_push_addr;
         for (k = 1; k < `BBC_STACK_DEPTH; k = k + 1) begin
            slot[k] <= slot[k-1];
         end
         o_top <= i_push_addr;
         if (depth != `BBC_STACK_DEPTH) begin
            depth <= depth + 3'h1;
         end
      end else if (i_pop) begin
         for (k = 0; k < `BBC_STACK_DEPTH - 1; k = k + 1) begin
            slot[k] <= slot[k+1];
         end
         o_top <= slot[1];
         if (!o_empty) begin
            depth <= depth - 3'h1;
         end
      end
   end

endmodule

// File: design/bbc_branch_bit_control.v
// Function
// - Short branches jump only when carry or zero condition holds.
// - Short branch: one byte, two cycles, 5-bit offset -15..+16, flags kept.
// - Bit-test branch: three bytes, five cycles, 8-bit offset -126..+129.
// - Bit-test branch copies tested bit into carry; zero unchanged.
// - Bit set/clear: two bytes, four cycles, one indexed bit, flags kept.
// - Bit operations reach any data-space byte by its address.
// - Jump and call: two bytes, four cycles, 12-bit target, flags kept.
// - Control instructions: one byte, two cycles; only interrupt return sets flags.
// - With watchdog option selected, stop executes as wait.
// - Bit-test opcode holds bit and polarity; then address, then offset.
`timescale 1ns/1ps
`include "bbc_map.vh"

module bbc_branch_bit_control (
   // Clock and reset
   input  wire        i_clock,
   input  wire        i_rst,
   // Instruction issue
   input  wire        i_start,
   input  wire [7:0]  i_opcode,
   input  wire [7:0]  i_byte2,
   input  wire [7:0]  i_byte3,
   input  wire [11:0] i_pc,
   input  wire        i_zero,
   input  wire        i_carry,
   input  wire        i_watchdog_opt,
   // Flags saved by the interrupt machinery
   input  wire        i_int_zero,
   input  wire        i_int_carry,
   // Data space access
   input  wire [7:0]  i_data_rd,
   output reg  [7:0]  o_data_addr,
   output reg         o_data_we,
   output reg  [7:0]  o_data_wr,
   // Completion
   output wire        o_busy,
   output reg         o_done,
   output reg  [11:0] o_next_pc,
   output reg         o_zero,
   output reg         o_carry,
   output reg         o_stop,
   output reg         o_wait,
   output reg         o_illegal
);

   function [2:0] bit_index;
      input [7:0] op;
      begin
         bit_index = {op[5], op[6], op[7]};
      end
   endfunction

   reg  [7:0]  op;
   reg  [7:0]  addr_byte;
   reg  [7:0]  disp_byte;
   reg  [11:0] pc;
   reg         zf;
   reg         cf;
   reg         wdg;
   reg  [2:0]  cnt;
   reg         run;
   reg  [7:0]  rd_byte;
   reg         next_push;
   reg         next_pop;
   reg  [11:0] next_pc;
   reg         next_z;
   reg         next_c;
   reg         next_we;
   reg  [7:0]  next_wr;
   reg         next_stop;
   reg         next_wait;
   reg         next_ill;
   reg  [2:0]  cycles;
   reg         tested;
   wire [11:0] ret_addr;

   wire [2:0]  cls = op[2:0];
   wire [11:0] short_off = {{7{op[7]}}, op[7:3]};
   wire [11:0] long_off = {{4{disp_byte[7]}}, disp_byte};
   wire        is_ctrl = (op == `BBC_OP_IDLE) || (op == `BBC_OP_RET) || (op == `BBC_OP_INTRET) ||
                         (op == `BBC_OP_STOP) || (op == `BBC_OP_WAIT);
   wire        ending = run && (cnt == 3'h1);

   assign o_busy = run;

   // Cycle count of the instruction about to start
   always @* begin
      case (i_opcode[2:0])
         `BBC_CLS_JUMP: cycles = `BBC_CYC_JUMP;
         `BBC_CLS_BIT:  cycles = i_opcode[`BBC_SUB_BIT] ? `BBC_CYC_BITOP
                                                        : `BBC_CYC_BITTEST;
         `BBC_CLS_IFNZ, `BBC_CLS_IFNC, `BBC_CLS_IFZ, `BBC_CLS_IFC:
                        cycles = `BBC_CYC_SHORT;
         default:       cycles = `BBC_CYC_CTRL;
      endcase
   end

   // Result of the latched instruction
   always @* begin
      tested    = rd_byte[bit_index(op)];
      next_pc   = pc + `BBC_LEN_SHORT;
      next_z    = zf;
      next_c    = cf;
      next_we   = 1'b0;
      next_wr   = rd_byte;
      next_push = 1'b0;
      next_pop  = 1'b0;
      next_stop = 1'b0;
      next_wait = 1'b0;
      next_ill  = 1'b0;
      case (cls)
         `BBC_CLS_IFNZ: if (!zf) next_pc = pc + short_off + `BBC_BIAS_SHORT;
         `BBC_CLS_IFNC: if (!cf) next_pc = pc + short_off + `BBC_BIAS_SHORT;
         `BBC_CLS_IFZ:  if (zf) next_pc = pc + short_off + `BBC_BIAS_SHORT;
         `BBC_CLS_IFC:  if (cf) next_pc = pc + short_off + `BBC_BIAS_SHORT;
         `BBC_CLS_JUMP: begin
            next_pc = {op[7:4], addr_byte};
            next_push = !op[`BBC_SUB_BIT];
         end
         `BBC_CLS_BIT: begin
            if (op[`BBC_SUB_BIT]) begin
               next_pc = pc + `BBC_LEN_BITOP;
               next_we = 1'b1;
               next_wr[bit_index(op)] = op[`BBC_POL_BIT];
            end else begin
               next_c = tested;
               if (tested == op[`BBC_POL_BIT]) begin
                  next_pc = pc + long_off + `BBC_BIAS_LONG;
               end else begin
                  next_pc = pc + `BBC_LEN_BITTEST;
               end
            end
         end
         default: begin
            case (op)
               `BBC_OP_IDLE: next_pc = pc + `BBC_LEN_SHORT;
               `BBC_OP_RET: begin
                  next_pc = ret_addr;
                  next_pop = 1'b1;
               end
               `BBC_OP_INTRET: begin
                  next_pc = ret_addr;
                  next_pop = 1'b1;
                  next_z = i_int_zero;
                  next_c = i_int_carry;
               end
               `BBC_OP_STOP: begin
                  next_stop = !wdg;
                  next_wait = wdg;
               end
               `BBC_OP_WAIT: next_wait = 1'b1;
               default: next_ill = !is_ctrl;
            endcase
         end
      endcase
   end

   always @(posedge i_clock) begin
      if (i_rst) begin
         run         <= 1'b0;
         cnt         <= 3'h0;
         op          <= `BBC_OP_IDLE;
         addr_byte   <= 8'h00;
         disp_byte   <= 8'h00;
         pc          <= `BBC_PC_RESET;
         zf          <= 1'b0;
         cf          <= 1'b0;
         wdg         <= 1'b0;
         rd_byte     <= 8'h00;
         o_data_addr <= 8'h00;
         o_data_we   <= 1'b0;
         o_data_wr   <= 8'h00;
         o_done      <= 1'b0;
         o_next_pc   <= `BBC_PC_RESET;
         o_zero      <= 1'b0;
         o_carry     <= 1'b0;
         o_stop      <= 1'b0;
         o_wait      <= 1'b0;
         o_illegal   <= 1'b0;
      end else begin
         o_done    <= 1'b0;
         o_data_we <= 1'b0;
         o_stop    <= 1'b0;
         o_wait    <= 1'b0;
         o_illegal <= 1'b0;
         if (!run && i_start) begin
            run         <= 1'b1;
            cnt         <= cycles;
            op          <= i_opcode;
            addr_byte   <= i_byte2;
            disp_byte   <= i_byte3;
            pc          <= i_pc;
            zf          <= i_zero;
            cf          <= i_carry;
            wdg         <= i_watchdog_opt;
            o_data_addr <= i_byte2;
         end else if (run) begin
            cnt <= cnt - 3'h1;
            // Read data is valid one cycle after the address is presented
            if (cnt == cycles_read(op)) begin
               rd_byte <= i_data_rd;
            end
            if (ending) begin
               run       <= 1'b0;
               o_done    <= 1'b1;
               o_next_pc <= next_pc;
               o_zero    <= next_z;
               o_carry   <= next_c;
               o_data_we <= next_we;
               o_data_wr <= next_wr;
               o_stop    <= next_stop;
               o_wait    <= next_wait;
               o_illegal <= next_ill;
            end
         end
      end
   end

   // Count value at which the operand byte is captured (second cycle of the op)
   function [2:0] cycles_read;
      input [7:0] o;
      begin
         cycles_read = o[`BBC_SUB_BIT] ? (`BBC_CYC_BITOP - 3'h1) : (`BBC_CYC_BITTEST - 3'h1);
      end
   endfunction

   bbc_return_stack u_stack (
      .i_clock     (i_clock),
      .i_rst       (i_rst),
      .i_push      (ending && next_push),
      .i_pop       (ending && next_pop),
      .i_push_addr (pc + `BBC_LEN_JUMP),
      .o_top       (ret_addr),
      .o_empty     ()
   );

endmodule

// File: tb/bbc_assertions.sv
`timescale 1ns/1ps
module bbc_checker (
   // Clock and reset
   input wire        i_clock,
   input wire        i_rst,
   // Issue
   input wire        i_start,
   input wire [7:0]  i_opcode,
   input wire [7:0]  i_byte2,
   input wire        i_zero,
   input wire        i_carry,
   input wire        i_watchdog_opt,
   input wire [7:0]  i_data_rd,
   // Results
   input wire        o_busy,
   input wire        o_done,
   input wire [11:0] o_next_pc,
   input wire [7:0]  o_data_addr,
   input wire        o_data_we,
   input wire [7:0]  o_data_wr,
   input wire        o_zero,
   input wire        o_carry,
   input wire        o_stop,
   input wire        o_wait
);
   wire       issue = i_start && !o_busy;
   reg  [7:0] op_q;
   reg  [7:0] b2_q;
   reg        z_q;
   reg        c_q;
   reg        wd_q;
   wire [2:0] idx = {op_q[5], op_q[6], op_q[7]};
   wire [7:0] mask = 8'h01 << idx;
   // Only opcodes known to keep both flags; interrupt return and bit test are excluded
   wire       kept = !op_q[0] || op_q[2:0] == 3'h1 || op_q[3:0] == 4'hb
                     || (op_q[4:0] == 5'h05 && op_q[7:5] <= 3'h4 && op_q[7:5] != 3'h2);

   // Busy blocks a new issue, so the captured fields hold until done
   always @(posedge i_clock) begin
      if (issue) begin
         op_q <= i_opcode;
         b2_q <= i_byte2;
         z_q  <= i_zero;
         c_q  <= i_carry;
         wd_q <= i_watchdog_opt;
      end
   end

   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (i_rst);

   // Done is sampled one edge after the edge that launches it
   a_short_two_cycles: assert property (issue && !i_opcode[0]
      |-> ##1 !o_done [*2] ##1 o_done) else $error("short branch length wrong");
   a_test_five_cycles: assert property (issue && i_opcode[3:0] == 4'h3
      |-> ##1 !o_done [*5] ##1 o_done) else $error("bit test length wrong");
   a_bitop_four_cycles: assert property (issue && i_opcode[3:0] == 4'hb
      |-> ##1 !o_data_we [*4] ##1 (o_done && o_data_we)) else $error("bit op length wrong");
   a_jump_target: assert property (issue && i_opcode[2:0] == 3'h1
      |-> ##5 o_done && o_next_pc == {op_q[7:4], b2_q}) else $error("jump target wrong");
   a_test_carry: assert property (o_done && op_q[3:0] == 4'h3
      |-> o_carry == |($past(i_data_rd, 4) & mask) && o_zero == z_q)
      else $error("tested bit not in carry");
   a_bitop_write: assert property (o_data_we |-> o_data_wr ==
      (op_q[4] ? $past(i_data_rd, 3) | mask : $past(i_data_rd, 3) & ~mask))
      else $error("bit op wrote wrong byte");
   a_bit_address: assert property (o_done && op_q[2:0] == 3'h3 |-> o_data_addr == b2_q)
      else $error("data address wrong");
   a_stop_as_wait: assert property (o_done && op_q == 8'h65
      |-> o_wait == wd_q && o_stop == !wd_q) else $error("stop substitution wrong");
   a_flags_kept: assert property (o_done && kept |-> o_zero == z_q && o_carry == c_q)
      else $error("flags changed");

   cover property (issue && i_opcode[3:0] == 4'h3);
   cover property (o_data_we);
   cover property (o_done && o_wait && wd_q);
endmodule

bind bbc_branch_bit_control bbc_checker chk_u (
   .i_clock(i_clock), .i_rst(i_rst), .i_start(i_start), .i_opcode(i_opcode),
   .i_byte2(i_byte2), .i_zero(i_zero), .i_carry(i_carry), .i_watchdog_opt(i_watchdog_opt),
   .i_data_rd(i_data_rd), .o_busy(o_busy), .o_done(o_done), .o_next_pc(o_next_pc),
   .o_data_addr(o_data_addr), .o_data_we(o_data_we), .o_data_wr(o_data_wr),
   .o_zero(o_zero), .o_carry(o_carry), .o_stop(o_stop), .o_wait(o_wait)
);

// File: tb/tb_branch_bit_control_decode.sv
`timescale 1ns/1ps
module tb_branch_bit_control_decode;
   logic        i_clock = 1'b0;
   logic        i_rst = 1'b1;
   logic        i_start = 1'b0;
   logic [7:0]  i_opcode = 8'h00;
   logic [7:0]  i_byte2 = 8'h00;
   logic [7:0]  i_byte3 = 8'h00;
   logic [11:0] i_pc = 12'h000;
   logic        i_zero = 1'b0;
   logic        i_carry = 1'b0;
   logic        i_watchdog_opt = 1'b0;
   logic        i_int_zero = 1'b0;
   logic        i_int_carry = 1'b0;
   logic [7:0]  i_data_rd = 8'h00;
   wire  [7:0]  o_data_addr;
   wire         o_data_we;
   wire  [7:0]  o_data_wr;
   wire         o_busy;
   wire         o_done;
   wire  [11:0] o_next_pc;
   wire         o_zero;
   wire         o_carry;
   wire         o_stop;
   wire         o_wait;
   wire         o_illegal;
   integer      mismatches = 0;
   integer      check_count = 0;
   integer      cycles = 0;
   integer      n;
   integer      i;

   bbc_branch_bit_control dut_u (
      .i_clock(i_clock), .i_rst(i_rst), .i_start(i_start), .i_opcode(i_opcode),
      .i_byte2(i_byte2), .i_byte3(i_byte3), .i_pc(i_pc), .i_zero(i_zero), .i_carry(i_carry),
      .i_watchdog_opt(i_watchdog_opt), .i_int_zero(i_int_zero), .i_int_carry(i_int_carry),
      .i_data_rd(i_data_rd), .o_data_addr(o_data_addr), .o_data_we(o_data_we),
      .o_data_wr(o_data_wr), .o_busy(o_busy), .o_done(o_done), .o_next_pc(o_next_pc),
      .o_zero(o_zero), .o_carry(o_carry), .o_stop(o_stop), .o_wait(o_wait),
      .o_illegal(o_illegal)
   );

   initial forever #25 i_clock = ~i_clock;

   task report_and_stop;
      begin
         if (mismatches == 0 && check_count > 0) begin
            $display("== PASSED ==");
         end else begin
            $display("== FAILED ==");
         end
         $finish;
      end
   endtask

   // Whole run needs well under a thousand cycles
   always @(posedge i_clock) begin
      cycles = cycles + 1;
      if (cycles == 2000) begin
         mismatches = mismatches + 1;
         report_and_stop;
      end
   end

   task chk(input logic [11:0] seen, input logic [11:0] exp);
      begin
         check_count = check_count + 1;
         if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask

   // Issues one instruction and waits for done; results are read at the done edge
   task step(input logic [7:0] op, input logic [7:0] b2, input logic [7:0] b3,
             input logic [11:0] pc, input logic [11:0] exp, input logic [3:0] nc);
      begin
         i_pc <= pc;
         @(posedge i_clock);
         i_start  <= 1'b1;
         i_opcode <= op;
         i_byte2  <= b2;
         i_byte3  <= b3;
         @(posedge i_clock);
         i_start <= 1'b0;
         n = 0;
         while (o_done !== 1'b1 && n < 9) begin
            @(posedge i_clock);
            n = n + 1;
            if (n == 1) begin
               chk(12'(o_busy), 12'h001);
            end
         end
         // Done is seen one edge after the edge that launches it
         chk(12'(n - 1), {8'h00, nc});
         chk(o_next_pc, exp);
      end
   endtask

   task t_short;
      logic [4:0] d;
      logic       t;
      begin
         for (i = 0; i < 16; i = i + 1) begin
            d = i[3] ? 5'h10 : 5'h0f;
            t = i[2] ^ ~(i[0] ^ i[1]);
            i_zero  <= i[2];
            i_carry <= ~i[2];
            step({d, i[1:0], 1'b0}, 8'h00, 8'h00, 12'h020,
                 t ? 12'h021 + {{7{d[4]}}, d} : 12'h021, 4'h2);
            chk(12'({o_zero, o_carry}), 12'({i[2], ~i[2]}));
         end
      end
   endtask

   task t_bits;
      logic [7:0] m;
      logic [7:0] d;
      logic       v;
      begin
         for (i = 0; i < 32; i = i + 1) begin
            m = 8'h01 << i[2:0];
            v = i[1] ^ i[3];
            d = v ? m : ~m;
            i_data_rd <= d;
            i_zero    <= i[0];
            i_carry   <= ~v;
            if (i[4]) begin
               step({i[0], i[1], i[2], i[3], 4'hb}, {3'h5, i[4:0]}, 8'h00, 12'h300,
                    12'h302, 4'h4);
               chk(12'(o_data_wr), 12'(i[3] ? d | m : d & ~m));
            end else begin
               step({i[0], i[1], i[2], i[3], 4'h3}, {3'h5, i[4:0]}, {i[0], {7{~i[0]}}},
                    12'h300, (v == i[3]) ? 12'h302 + {{5{i[0]}}, {7{~i[0]}}} : 12'h303,
                    4'h5);
            end
            chk(12'({o_data_we, o_zero, o_carry}), 12'({i[4], i[0], v ^ i[4]}));
            chk(12'(o_data_addr), 12'({3'h5, i[4:0]}));
         end
      end
   endtask

   task t_flow;
      begin
         i_zero      <= 1'b1;
         i_carry     <= 1'b0;
         i_int_carry <= 1'b1;
         step(8'ha9, 8'h3c, 8'h00, 12'h7fe, 12'ha3c, 4'h4);
         step(8'h21, 8'haa, 8'h00, 12'h100, 12'h2aa, 4'h4);
         step(8'h31, 8'hbb, 8'h00, 12'h2aa, 12'h3bb, 4'h4);
         step(8'h25, 8'h00, 8'h00, 12'h3bb, 12'h2ac, 4'h2);
         step(8'h05, 8'h00, 8'h00, 12'h2ac, 12'h2ad, 4'h2);
         chk(12'({o_zero, o_carry}), 12'h002);
         step(8'h45, 8'h00, 8'h00, 12'h2ad, 12'h102, 4'h2);
         chk(12'({o_zero, o_carry}), 12'h001);
         step(8'h15, 8'h00, 8'h00, 12'h040, 12'h041, 4'h2);
         chk(12'({o_illegal, o_stop, o_wait}), 12'h004);
         for (i = 0; i < 3; i = i + 1) begin
            i_watchdog_opt <= i[0];
            step(i[1] ? 8'h85 : 8'h65, 8'h00, 8'h00, 12'h040, 12'h041, 4'h2);
            chk(12'({o_stop, o_wait}), 12'({~i[0] & ~i[1], i[0] | i[1]}));
         end
      end
   endtask

   initial begin
      repeat (3) @(posedge i_clock);
      i_rst <= 1'b0;
      t_short;
      t_bits;
      t_flow;
      report_and_stop;
   end
endmodule
